// file: pkg/disk_status_pkg.sv
// Package for the disk controller status-flag block: register map,
// status byte layout, command codes and reset values.
// Assumes a 32-bit APB register bus with word-aligned registers.
package disk_status_pkg;

  // Register byte offsets
  localparam logic [7:0] SELECT_OFS   = 8'h00;
  localparam logic [7:0] COMMAND_OFS  = 8'h04;
  localparam logic [7:0] CONTROL_OFS  = 8'h08;
  localparam logic [7:0] STATUS_OFS   = 8'h0C;
  localparam logic [7:0] IRQ_STS_OFS  = 8'h10;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h14;

  // Select address that this controller answers to
  localparam logic [7:0] DEV_SEL_ADDR = 8'h87;
  // Byte returned when the controller is not selected
  localparam logic [7:0] OPEN_BUS     = 8'hFF;

  // Status byte bit positions
  localparam int WP_BIT       = 0;
  localparam int RD_ERR_BIT   = 5;
  localparam int NOT_BUSY_BIT = 7;

  // Control register bit positions (write-only pulses)
  localparam int DEV_CLEAR_BIT = 0;
  localparam int INIT_BIT      = 1;

  // Interrupt status bit positions
  localparam int IRQ_DONE_BIT = 0;
  localparam int IRQ_WP_BIT   = 1;
  localparam int IRQ_RDE_BIT  = 2;
  localparam int IRQ_W        = 3;

  // Disk command codes, bits 2:0 of the command register
  localparam logic [2:0] CMD_UPD_READ  = 3'h0;
  localparam logic [2:0] CMD_UPD_WRITE = 3'h1;
  localparam logic [2:0] CMD_UPD_CHECK = 3'h2;
  localparam logic [2:0] CMD_READ      = 3'h3;
  localparam logic [2:0] CMD_WRITE     = 3'h4;
  localparam logic [2:0] CMD_CHECK     = 3'h5;
  localparam logic [2:0] CMD_RESTORE   = 3'h6;
  localparam logic [2:0] CMD_INIT_TRK  = 3'h7;

  // Reset values
  localparam logic [IRQ_W-1:0] IRQ_MASK_RST = 3'h0;
  localparam logic [2:0]       CMD_RST      = 3'h0;

  // Command progress states
  typedef enum logic {ST_IDLE, ST_BUSY} op_state_t;

endpackage

// file: design/sync2.sv
// Two-flop synchroniser for a group of independent level inputs.
// Assumes each bit is a slow level; multi-bit coherence is not kept.
`timescale 1ns/1ns
module sync2 #(
  parameter int W = 1
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Asynchronous levels in, synchronised levels out
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;

  // First stage feeds only the second stage
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      meta_q   <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end

endmodule

// file: design/sticky_bits.sv
// Sticky event bits, cleared by writing a one to them.
// Assumes set and clear pulses are on the same clock as the bits.
`timescale 1ns/1ns
module sticky_bits #(
  parameter int W = 3
) (
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Event pulses and write-one-to-clear strobes
  input  wire logic [W-1:0] set_in,
  input  wire logic [W-1:0] clr_in,
  output logic      [W-1:0] bits_q
);

  logic [W-1:0] bits_d;

  // A set in the clearing cycle wins, so no event is lost
  assign bits_d = (bits_q & ~clr_in) | set_in;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      bits_q <= '0;
    else
      bits_q <= bits_d;

endmodule

// file: design/disk_status_flags.sv
// Status flags and command progress of a hard disk controller, APB slave.
// Assumes drive signals arrive asynchronously and the APB master follows
// the usual setup/access sequence on pclk.
//
// Local design decisions: the APB interface to the registers and the register addresses.
`timescale 1ns/1ns
module disk_status_flags (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Drive side levels, asynchronous
  input  wire logic        drive_protect,
  input  wire logic        format_allow,
  input  wire logic        sector_unwritten,
  input  wire logic        op_done,
  // Interrupt
  output logic             irq
);

  // Synchronised drive levels
  logic [3:0] drv_s;
  logic       wp_s;
  logic       fa_s;
  logic       unw_s;
  logic       done_s;
  logic       done_prev_q;
  logic       done_evt;

  sync2 #(.W(4)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({op_done, sector_unwritten, format_allow, drive_protect}),
    .sync_out (drv_s)
  );

  assign wp_s   = drv_s[0];
  assign fa_s   = drv_s[1];
  assign unw_s  = drv_s[2];
  assign done_s = drv_s[3];

  // Completion edge taken from the synchronised level only
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      done_prev_q <= 1'b0;
    else
      done_prev_q <= done_s;

  assign done_evt = done_s & ~done_prev_q;

  // APB decode; zero wait states, so access phase always completes
  logic setup_ph;
  logic wr_en;
  logic hit_sel;
  logic hit_cmd;
  logic hit_ctl;
  logic hit_sts;
  logic hit_isr;
  logic hit_msk;
  logic mapped;

  assign setup_ph = psel & ~penable;
  assign wr_en    = psel & penable & pwrite;
  assign hit_sel  = paddr == disk_status_pkg::SELECT_OFS;
  assign hit_cmd  = paddr == disk_status_pkg::COMMAND_OFS;
  assign hit_ctl  = paddr == disk_status_pkg::CONTROL_OFS;
  assign hit_sts  = paddr == disk_status_pkg::STATUS_OFS;
  assign hit_isr  = paddr == disk_status_pkg::IRQ_STS_OFS;
  assign hit_msk  = paddr == disk_status_pkg::IRQ_MASK_OFS;
  assign mapped   = hit_sel | hit_cmd | hit_ctl | hit_sts | hit_isr
                  | hit_msk;
  assign pready   = 1'b1;
  assign pslverr  = psel & penable & ~mapped;

  // Instruction strobes; clear and initialize override any command
  logic dclr_wr;
  logic init_wr;
  logic abort;
  logic sel_wr;
  logic start;
  logic [2:0] new_cmd;

  assign dclr_wr = wr_en & hit_ctl & pwdata[disk_status_pkg::DEV_CLEAR_BIT];
  assign init_wr = wr_en & hit_ctl & pwdata[disk_status_pkg::INIT_BIT];
  assign abort   = dclr_wr | init_wr;
  assign sel_wr  = wr_en & hit_sel;
  assign new_cmd = pwdata[2:0];

  // Controller selection state
  logic       selected_q;
  logic       selected_d;
  logic [7:0] sel_addr_q;

  assign selected_d = init_wr ? 1'b0 :
                      sel_wr  ? (pwdata[7:0] == disk_status_pkg::DEV_SEL_ADDR)
                              : selected_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      selected_q <= 1'b0;
      sel_addr_q <= '0;
    end
    else
    begin
      selected_q <= selected_d;
      if (sel_wr)
        sel_addr_q <= pwdata[7:0];
    end

  // Commands taken only when selected and idle; others are dropped
  disk_status_pkg::op_state_t state_q;
  disk_status_pkg::op_state_t state_d;
  logic [2:0] cmd_q;
  logic       not_busy_q;
  logic       is_read;
  logic       finish;

  assign start  = wr_en & hit_cmd & selected_q
                & (state_q == disk_status_pkg::ST_IDLE);
  assign finish = (state_q == disk_status_pkg::ST_BUSY) & done_evt & ~abort;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      disk_status_pkg::ST_IDLE:
        if (start)
          state_d = disk_status_pkg::ST_BUSY;
      disk_status_pkg::ST_BUSY:
        if (abort || done_evt)
          state_d = disk_status_pkg::ST_IDLE;
      default:
        state_d = disk_status_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      state_q <= disk_status_pkg::ST_IDLE;
      cmd_q   <= disk_status_pkg::CMD_RST;
    end
    else
    begin
      state_q <= state_d;
      if (start)
        cmd_q <= new_cmd;
    end

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      not_busy_q <= 1'b1;
    else
      not_busy_q <= (state_d == disk_status_pkg::ST_IDLE);

  // Write-protect flag, judged when the command is issued
  logic wp_q;
  logic wp_d;
  logic wp_set;

  assign wp_set = start
    & (((new_cmd == disk_status_pkg::CMD_WRITE) & wp_s)
    | ((new_cmd == disk_status_pkg::CMD_INIT_TRK) & (wp_s | ~fa_s)));

  assign wp_d = abort ? 1'b0 : (wp_q | wp_set);

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      wp_q <= 1'b0;
    else
      wp_q <= wp_d;

  // Read error flag, judged when the command finishes
  logic rde_q;
  logic rde_d;

  assign is_read = (cmd_q == disk_status_pkg::CMD_UPD_READ)
                 | (cmd_q == disk_status_pkg::CMD_UPD_CHECK)
                 | (cmd_q == disk_status_pkg::CMD_READ)
                 | (cmd_q == disk_status_pkg::CMD_CHECK);

  assign rde_d = abort  ? 1'b0 :
                 finish ? (is_read & unw_s) : rde_q;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      rde_q <= 1'b0;
    else
      rde_q <= rde_d;

  logic [7:0] status_byte;

  always_comb
  begin
    status_byte = 8'h00;
    status_byte[disk_status_pkg::NOT_BUSY_BIT] = not_busy_q;
    status_byte[disk_status_pkg::RD_ERR_BIT]   = rde_q;
    status_byte[disk_status_pkg::WP_BIT]       = wp_q;
  end

  // Interrupts: completion, protect fault, read error
  logic [disk_status_pkg::IRQ_W-1:0] isr_q;
  logic [disk_status_pkg::IRQ_W-1:0] isr_set;
  logic [disk_status_pkg::IRQ_W-1:0] isr_clr;
  logic [disk_status_pkg::IRQ_W-1:0] mask_q;

  assign isr_set = {finish & is_read & unw_s, wp_set, finish};
  assign isr_clr = (wr_en & hit_isr)
                 ? pwdata[disk_status_pkg::IRQ_W-1:0] : '0;

  sticky_bits #(.W(disk_status_pkg::IRQ_W)) u_isr (
    .pclk    (pclk),
    .presetn (presetn),
    .set_in  (isr_set),
    .clr_in  (isr_clr),
    .bits_q  (isr_q)
  );

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      mask_q <= disk_status_pkg::IRQ_MASK_RST;
    else if (wr_en && hit_msk)
      mask_q <= pwdata[disk_status_pkg::IRQ_W-1:0];

  assign irq = |(isr_q & mask_q);

  // Read data captured in setup phase, held through access
  logic [31:0] rd_mux;
  logic [31:0] prdata_q;

  assign rd_mux =
    hit_sel ? {24'h000000, sel_addr_q} :
    hit_sts ? {24'h000000, selected_q ? status_byte
                                      : disk_status_pkg::OPEN_BUS} :
    hit_isr ? {29'h00000000, isr_q} :
    hit_msk ? {29'h00000000, mask_q} : 32'h00000000;

  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      prdata_q <= 32'h00000000;
    else if (setup_ph)
      prdata_q <= rd_mux;

  assign prdata = prdata_q;

  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_running;
    (state_q == disk_status_pkg::ST_BUSY) && !abort && !done_evt;
  endsequence

  sequence s_start_cmd;
    start && !abort;
  endsequence

  a_busy_flag_low: assert property (
    s_running |=> !not_busy_q)
    else $error("not-busy high while command runs");

  a_done_sets_ready: assert property (
    finish |=> not_busy_q && status_byte[disk_status_pkg::NOT_BUSY_BIT])
    else $error("not-busy low after completion");

  a_clear_aborts: assert property (
    dclr_wr |=> not_busy_q && state_q == disk_status_pkg::ST_IDLE)
    else $error("device clear did not abort");

  a_init_aborts: assert property (
    init_wr |=> not_busy_q && !selected_q)
    else $error("initialize did not abort");

  a_wp_on_write: assert property (
    s_start_cmd ##0 (new_cmd == disk_status_pkg::CMD_WRITE && wp_s)
    |=> wp_q ##0 status_byte[0])
    else $error("protected write missed flag");

  a_wp_unprot_hold: assert property (
    s_start_cmd ##0 (!wp_s && new_cmd != disk_status_pkg::CMD_INIT_TRK)
    |=> wp_q == $past(wp_q))
    else $error("unprotected command set flag");

  a_wp_abort_clr: assert property (
    abort |=> !wp_q && !rde_q)
    else $error("abort left flags set");

  a_fmt_allow_gate: assert property (
    s_start_cmd ##0 (new_cmd == disk_status_pkg::CMD_INIT_TRK && !wp_s)
    |=> wp_q == ($past(wp_q) | !$past(fa_s)))
    else $error("format-allow gating wrong");

  a_rde_on_read: assert property (
    finish && is_read && unw_s |=> rde_q ##1 (rde_q || $past(abort) ||
      $past(finish)))
    else $error("read error not set");

  a_rde_other_clr: assert property (
    finish && !is_read |=> !rde_q)
    else $error("read error not cleared");

  a_open_bus: assert property (
    setup_ph && hit_sts && !selected_q
    |=> prdata[7:0] == disk_status_pkg::OPEN_BUS)
    else $error("unselected status not open bus");

endmodule

// file: dv/drive_model.sv
// Drive mechanism model: answers a started command with op_done.
// Assumes go is a one-cycle pulse on pclk and lat sets the delay.
`timescale 1ns/1ns
module drive_model (
  // Clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Start and delay from the bench
  input  wire logic       go,
  input  wire logic [7:0] lat,
  // Completion level to the block
  output logic            op_done
);
  int cnt_q;

  // Delay, then a 3-cycle done pulse; driven low between pulses
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q   <= 0;
      op_done <= 1'b0;
    end
    else
    begin
      if (go)
        cnt_q <= int'(lat) + 3;
      else if (cnt_q > 0)
        cnt_q <= cnt_q - 1;
      op_done <= (cnt_q > 0) && (cnt_q <= 3) && !go;
    end
  end
endmodule

// file: dv/disk_status_flags_tb.sv
// Self-checking bench for the disk status flag block.
// Assumes the drive model answers commands; APB master held to pready.
`timescale 1ns/1ns
module disk_status_flags_tb;
  typedef struct {
    logic [2:0] cmd;
    logic [3:0] f;
    logic [7:0] exp;
  } row_t;

  logic        pclk, presetn, psel, penable, pwrite;
  logic [7:0]  paddr, lat, prev;
  logic [31:0] pwdata, prdata, rd, bsy, be;
  logic        pready, pslverr, irq, op_done, go, err;
  logic        drive_protect, format_allow, sector_unwritten;
  int          n_fail, check_count;
  row_t        rows [12];

  disk_status_flags DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .drive_protect(drive_protect), .format_allow(format_allow),
    .sector_unwritten(sector_unwritten), .op_done(op_done), .irq(irq));

  drive_model drv (.pclk(pclk), .presetn(presetn), .go(go), .lat(lat),
    .op_done(op_done));

  // 100 MHz clock
  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic end_sim();
  begin
    if (n_fail == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  end
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
    input string m);
  begin
    check_count++;
    if (got !== exp)
    begin
      n_fail++;
      $display("CHECK FAILED %0t %s got %h exp %h", $time, m, got, exp);
    end
  end
  endtask

  // One APB transfer; request held until pready is sampled high
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    int k;
  begin
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge pclk);
      k++;
    end
    while (pready !== 1'b1 && k < 20);
    if (pready !== 1'b1)
    begin
      n_fail++;
      $display("CHECK FAILED %0t pready timeout", $time);
      end_sim();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  end
  endtask

  // Status read with compare against one byte
  task automatic rs(input logic [7:0] e, input string m);
  begin
    apb(1'b0, disk_status_pkg::STATUS_OFS, 32'h0);
    chk(rd, {24'h0, e}, m);
  end
  endtask

  // Poll status until not busy; bounded so a stuck flag ends the run
  task automatic wait_idle();
    int k;
  begin
    k = 0;
    do
    begin
      apb(1'b0, disk_status_pkg::STATUS_OFS, 32'h0);
      k++;
    end
    while (rd[7] !== 1'b1 && k < 100);
    if (rd[7] !== 1'b1)
    begin
      n_fail++;
      $display("CHECK FAILED %0t not-busy timeout", $time);
      end_sim();
    end
  end
  endtask

  // Command, busy snapshot, drive answer after l cycles, wait done
  task automatic op(input logic [2:0] c, input logic [7:0] l);
  begin
    apb(1'b1, disk_status_pkg::COMMAND_OFS, {29'h0, c});
    apb(1'b0, disk_status_pkg::STATUS_OFS, 32'h0);
    bsy = rd;
    go <= 1'b1;
    lat <= l;
    @(posedge pclk);
    go <= 1'b0;
    wait_idle();
  end
  endtask

  // Hang guard at 50k cycles, well above the run
  initial
  begin
    #500000;
    n_fail++;
    $display("CHECK FAILED %0t run timeout", $time);
    end_sim();
  end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    drive_protect = 1'b0;
    format_allow = 1'b1;
    sector_unwritten = 1'b1;
    go = 1'b0;
    lat = 8'h00;
    n_fail = 0;
    check_count = 0;
    // Flags: clear first, protect, format allow, unwritten sector
    rows = '{'{disk_status_pkg::CMD_UPD_READ, 4'h3, 8'hA0},
      '{disk_status_pkg::CMD_UPD_WRITE, 4'h3, 8'h80},
      '{disk_status_pkg::CMD_UPD_CHECK, 4'h3, 8'hA0},
      '{disk_status_pkg::CMD_RESTORE, 4'h3, 8'h80},
      '{disk_status_pkg::CMD_READ, 4'h3, 8'hA0},
      '{disk_status_pkg::CMD_READ, 4'h2, 8'h80},
      '{disk_status_pkg::CMD_CHECK, 4'h3, 8'hA0},
      '{disk_status_pkg::CMD_INIT_TRK, 4'h3, 8'h80},
      '{disk_status_pkg::CMD_WRITE, 4'h2, 8'h80},
      '{disk_status_pkg::CMD_INIT_TRK, 4'h0, 8'h81},
      '{disk_status_pkg::CMD_WRITE, 4'hE, 8'h81},
      '{disk_status_pkg::CMD_INIT_TRK, 4'hE, 8'h81}};
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rs(8'hFF, "unselected");
    apb(1'b0, disk_status_pkg::IRQ_MASK_OFS, 32'h0);
    chk(rd, 32'h0, "mask reset");
    apb(1'b1, disk_status_pkg::SELECT_OFS, 32'h0F);
    rs(8'hFF, "wrong select");
    apb(1'b1, disk_status_pkg::SELECT_OFS, 32'h87);
    rs(8'h80, "selected idle");
    apb(1'b0, 8'h18, 32'h0);
    chk({31'h0, err}, 32'h1, "unmapped err");
    prev = 8'h80;
    // Table of commands with drive levels
    foreach (rows[i])
    begin
      if (rows[i].f[3])
      begin
        apb(1'b1, disk_status_pkg::CONTROL_OFS, 32'h1);
        prev = 8'h80;
      end
      drive_protect <= rows[i].f[2];
      format_allow <= rows[i].f[1];
      sector_unwritten <= rows[i].f[0];
      repeat (3) @(posedge pclk);
      op(rows[i].cmd, 8'(4 * i + 1));
      be = {24'h0, prev & 8'h20 | rows[i].exp & 8'h01};
      chk(bsy, be, "busy");
      chk(rd, {24'h0, rows[i].exp}, "done");
      prev = rows[i].exp;
    end
    // Interrupt: pending but masked, then unmasked, then cleared
    apb(1'b0, disk_status_pkg::IRQ_STS_OFS, 32'h0);
    chk(rd, 32'h7, "irq status");
    chk({31'h0, irq}, 32'h0, "irq masked");
    apb(1'b1, disk_status_pkg::IRQ_MASK_OFS, 32'h1);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h1, "irq raised");
    apb(1'b1, disk_status_pkg::IRQ_STS_OFS, 32'h7);
    @(negedge pclk);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    // Device clear in mid-command with both flags set
    @(posedge pclk);
    sector_unwritten <= 1'b1;
    repeat (3) @(posedge pclk);
    op(disk_status_pkg::CMD_WRITE, 8'h01);
    op(disk_status_pkg::CMD_READ, 8'h01);
    chk(rd, 32'hA1, "both flags");
    apb(1'b1, disk_status_pkg::COMMAND_OFS, 32'h3);
    rs(8'h21, "busy");
    apb(1'b1, disk_status_pkg::CONTROL_OFS, 32'h1);
    rs(8'h80, "clear abort");
    // Initialize in mid-command, then reselect
    op(disk_status_pkg::CMD_WRITE, 8'h08);
    op(disk_status_pkg::CMD_READ, 8'h01);
    apb(1'b1, disk_status_pkg::COMMAND_OFS, 32'h0);
    apb(1'b1, disk_status_pkg::CONTROL_OFS, 32'h2);
    rs(8'hFF, "init deselect");
    apb(1'b1, disk_status_pkg::SELECT_OFS, 32'h87);
    rs(8'h80, "init abort");
    end_sim();
  end
endmodule
